/* File: verilog/ldc_core.sv */
`timescale 1ns/10ps
// What this block does
// - amplitude from code, or pin when selected
// - eight-bit modulation code sets modulation current
// - power-down bit disables whole transmit path
// - offset cancellation on unless disable bit
// - crosspoint direction and seven-bit magnitude
// - bias off after reset, on when enabled
// - open loop uses code, else power loop
// - photodiode polarity selects sink or source
// - two-bit photodiode range selects feedback range
// - bias sources by default, sinks when set
// - digital monitor selects give ten-bit words
// - bias fault from comparator or threshold
// - photodiode fault from comparator or threshold
// - fault on overcurrent or large bias drop
// - fault zeroes bias, latches pin, status
// - toggle disable or enable clears latch
// - recover after negate time or reassert
// - reset defaults, init and ready times
// - disable pin kills bias, keeps registers
// - adc result split across two registers
// - three-bit channel select picks quantity
// - adc runs only with both enables
module ldc_core #(
    parameter int ADC_W = 10
) (
    input wire logic mclk, // board clock
    input wire logic rst_n, // synchronous reset
    input wire logic [7:0] reg_addr, // register index
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic disable_pin, // async disable input
    input wire logic bias_monitor_pin, // bias comparator over bandgap
    input wire logic pd_monitor_pin, // pd comparator over bandgap
    input wire logic [9:0] bias_meas, // measured bias word
    input wire logic [9:0] pd_meas, // measured pd word
    input wire logic [ADC_W-1:0] adc_result, // converter output
    input wire logic adc_done, // converter result strobe
    output logic fault_latch, // fault pin
    output logic tx_ready, // transmit allowed
    output logic regs_ready, // registers writable
    output ldc_pkg::ldc_bias_t bias_ctl, // bias driver control
    output ldc_pkg::ldc_tx_t tx_ctl, // transmit path control
    output ldc_pkg::ldc_mon_ctl_t mon_ctl // monitor mux control
);
    logic [7:0] core0_ff, core1_ff, adccfg_ff, txctl_ff, mod_ff, xp_ff;
    logic [7:0] bias_lo_ff, bias_hi_ff, bthr_ff, pthr_ff, pdset_ff;
    logic [ADC_W-1:0] adc_ff;
    logic [7:0] reg_rdata_ff;
    logic dis_s1_ff, dis_s2_ff;
    logic mb_s1_ff, mb_s2_ff, mp_s1_ff, mp_s2_ff;
    logic fault_ff, fault_pin_ff;
    logic [9:0] bias_prev_ff;
    logic [15:0] rec_cnt_ff, neg_cnt_ff, pwr_cnt_ff;
    logic rec_done_ff;
    ldc_pkg::ldc_pwr_t pwr_ff;
    logic wr_ok, off_req, fault_now, big_drop, pd_over;
    logic [9:0] bias_code, pd_thr10, b_thr10;

    function automatic logic [9:0] thr10(input logic [7:0] t);
        thr10 = {t, 2'b00};
    endfunction

    assign wr_ok = reg_wr && (pwr_ff != ldc_pkg::ST_INIT);
    assign bias_code = {bias_hi_ff[1:0], bias_lo_ff};
    assign b_thr10 = thr10(bthr_ff);
    assign pd_thr10 = thr10(pthr_ff);

    // power-on sequencing
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pwr_ff <= ldc_pkg::ST_INIT;
            pwr_cnt_ff <= 16'h0000;
        end else begin
            unique case (pwr_ff)
                ldc_pkg::ST_INIT: begin
                    if (pwr_cnt_ff == 16'(ldc_pkg::INIT1_CYC - 1)) begin
                        pwr_ff <= ldc_pkg::ST_WAIT;
                        pwr_cnt_ff <= 16'h0000;
                    end else begin
                        pwr_cnt_ff <= pwr_cnt_ff + 16'h0001;
                    end
                end
                ldc_pkg::ST_WAIT: begin
                    if (pwr_cnt_ff == 16'(ldc_pkg::INIT2_CYC - 1)) begin
                        pwr_ff <= ldc_pkg::ST_RUN;
                    end else begin
                        pwr_cnt_ff <= pwr_cnt_ff + 16'h0001;
                    end
                end
                ldc_pkg::ST_RUN: pwr_ff <= ldc_pkg::ST_RUN;
            endcase
        end
    end

    // register writes; everything lands on defaults at reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            core0_ff <= ldc_pkg::RST_CORE0;
            core1_ff <= ldc_pkg::RST_ZERO;
            adccfg_ff <= ldc_pkg::RST_ZERO;
            txctl_ff <= ldc_pkg::RST_ZERO;
            mod_ff <= ldc_pkg::RST_ZERO;
            xp_ff <= ldc_pkg::RST_ZERO;
            bias_lo_ff <= ldc_pkg::RST_ZERO;
            bias_hi_ff <= ldc_pkg::RST_ZERO;
            bthr_ff <= ldc_pkg::RST_ZERO;
            pthr_ff <= ldc_pkg::RST_ZERO;
            pdset_ff <= ldc_pkg::RST_ZERO;
        end else if (wr_ok) begin
            unique case (reg_addr)
                ldc_pkg::REG_CORE0: core0_ff <= reg_wdata;
                ldc_pkg::REG_CORE1: core1_ff <= reg_wdata;
                ldc_pkg::REG_ADCCFG: adccfg_ff <= reg_wdata;
                ldc_pkg::REG_TXCTL: txctl_ff <= reg_wdata;
                ldc_pkg::REG_MODCODE: mod_ff <= reg_wdata;
                ldc_pkg::REG_XPOINT: xp_ff <= reg_wdata;
                ldc_pkg::REG_BIAS_LO: bias_lo_ff <= reg_wdata;
                ldc_pkg::REG_BIAS_HI: bias_hi_ff <= reg_wdata;
                ldc_pkg::REG_BIAS_THR: bthr_ff <= reg_wdata;
                ldc_pkg::REG_PD_THR: pthr_ff <= reg_wdata;
                ldc_pkg::REG_PD_SET: pdset_ff <= reg_wdata;
                default: core0_ff <= core0_ff;
            endcase
        end
    end

    // converter result capture
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            adc_ff <= '0;
        end else if (adc_done && mon_ctl.adc_run) begin
            adc_ff <= adc_result;
        end
    end

    // read port, unmapped reads zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ldc_pkg::REG_CORE0: reg_rdata_ff <= core0_ff;
                ldc_pkg::REG_CORE1: reg_rdata_ff <= core1_ff;
                ldc_pkg::REG_ADCCFG: reg_rdata_ff <= adccfg_ff;
                ldc_pkg::REG_TXCTL: reg_rdata_ff <= txctl_ff;
                ldc_pkg::REG_MODCODE: reg_rdata_ff <= mod_ff;
                ldc_pkg::REG_XPOINT: reg_rdata_ff <= xp_ff;
                ldc_pkg::REG_BIAS_LO: reg_rdata_ff <= bias_lo_ff;
                ldc_pkg::REG_BIAS_HI: reg_rdata_ff <= bias_hi_ff;
                ldc_pkg::REG_BIAS_THR: reg_rdata_ff <= bthr_ff;
                ldc_pkg::REG_PD_THR: reg_rdata_ff <= pthr_ff;
                ldc_pkg::REG_PD_SET: reg_rdata_ff <= pdset_ff;
                ldc_pkg::REG_ADC_MSB: reg_rdata_ff <= adc_ff[ADC_W-1 -: 8];
                ldc_pkg::REG_ADC_LSB: reg_rdata_ff <= {6'h00, adc_ff[1:0]};
                ldc_pkg::REG_STATUS: reg_rdata_ff <= 8'(fault_ff) << ldc_pkg::B_FLT_STAT;
                default: reg_rdata_ff <= 8'h00;
            endcase
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_ff;

    // pins from outside the clock domain
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dis_s1_ff <= 1'b1;
            dis_s2_ff <= 1'b1;
            mb_s1_ff <= 1'b0;
            mb_s2_ff <= 1'b0;
            mp_s1_ff <= 1'b0;
            mp_s2_ff <= 1'b0;
        end else begin
            dis_s1_ff <= disable_pin;
            dis_s2_ff <= dis_s1_ff;
            mb_s1_ff <= bias_monitor_pin;
            mb_s2_ff <= mb_s1_ff;
            mp_s1_ff <= pd_monitor_pin;
            mp_s2_ff <= mp_s1_ff;
        end
    end

    // disabled by pin or by cleared enable bit
    assign off_req = dis_s2_ff || !core1_ff[ldc_pkg::B_BIAS_EN];

    // photodiode over 150% of set point: 2*meas > 3*set
    assign pd_over = ({1'b0, pd_meas, 1'b0} > ({2'b00, pdset_ff, 2'b00} - {4'h0, pdset_ff}))
        && (pdset_ff != 8'h00);
    // bias code falling below half its previous value in one step
    assign big_drop = ({1'b0, bias_code} < {2'b00, bias_prev_ff[9:1]}) && !off_req;

    assign fault_now = core1_ff[ldc_pkg::B_FLT_EN] && (
        mb_s2_ff ||
        (bias_hi_ff[ldc_pkg::B_DMON_B] && (bias_meas > b_thr10)) ||
        (mp_s2_ff && core1_ff[ldc_pkg::B_PD_FLT_TRIG]) ||
        (bias_hi_ff[ldc_pkg::B_DMON_P] && (pd_meas > pd_thr10)) ||
        pd_over || big_drop);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bias_prev_ff <= 10'h000;
        end else begin
            bias_prev_ff <= bias_code;
        end
    end

    // latch clear needs disable held for the reset time
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rec_cnt_ff <= 16'h0000;
            rec_done_ff <= 1'b0;
        end else if (!off_req) begin
            rec_cnt_ff <= 16'h0000;
            rec_done_ff <= 1'b0;
        end else if (rec_cnt_ff == 16'(ldc_pkg::FLTRST_CYC - 1)) begin
            rec_done_ff <= 1'b1;
        end else begin
            rec_cnt_ff <= rec_cnt_ff + 16'h0001;
        end
    end

    // fault state: set wins over the recovery clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_ff <= 1'b0;
        end else if (fault_now && !off_req) begin
            fault_ff <= 1'b1;
        end else if (rec_done_ff) begin
            fault_ff <= 1'b0;
        end
    end

    // pin follows the latch but drops while disabled
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_pin_ff <= 1'b0;
        end else begin
            fault_pin_ff <= fault_ff && !off_req;
        end
    end
    assign fault_latch = fault_pin_ff;

    // bias returns only after the negate time with no fault
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            neg_cnt_ff <= 16'h0000;
        end else if (off_req || fault_ff || pwr_ff != ldc_pkg::ST_RUN) begin
            neg_cnt_ff <= 16'h0000;
        end else if (neg_cnt_ff != 16'(ldc_pkg::NEGATE_CYC)) begin
            neg_cnt_ff <= neg_cnt_ff + 16'h0001;
        end
    end

    assign regs_ready = (pwr_ff != ldc_pkg::ST_INIT);
    assign tx_ready = (pwr_ff == ldc_pkg::ST_RUN) && core0_ff[ldc_pkg::B_CHIP_EN]
        && !dis_s2_ff;

    always_comb begin
        bias_ctl.bias_on = tx_ready && !off_req && !fault_ff
            && (neg_cnt_ff == 16'(ldc_pkg::NEGATE_CYC));
        bias_ctl.bias_sink = core1_ff[ldc_pkg::B_BIAS_POL];
        bias_ctl.open_loop = core1_ff[ldc_pkg::B_OPEN_LOOP];
        bias_ctl.pd_sink = core1_ff[ldc_pkg::B_PD_POL];
        bias_ctl.pd_range = core1_ff[ldc_pkg::B_PD_RNG_LO +: 2];
        bias_ctl.bias_code = bias_ctl.bias_on ? bias_code : 10'h000;
    end

    always_comb begin
        tx_ctl.tx_powerdown = txctl_ff[ldc_pkg::B_TX_PD] || !tx_ready;
        tx_ctl.amp_from_pin = txctl_ff[ldc_pkg::B_AMP_SRC];
        tx_ctl.offset_cancel_on = !txctl_ff[ldc_pkg::B_OC_DIS];
        tx_ctl.modulation_code = mod_ff;
        tx_ctl.crosspoint_direction = xp_ff[ldc_pkg::B_XP_DIR];
        tx_ctl.crosspoint_magnitude = xp_ff[6:0];
    end

    always_comb begin
        mon_ctl.adc_run = adccfg_ff[ldc_pkg::B_ADC_OSC] && adccfg_ff[ldc_pkg::B_ADC_EN];
        mon_ctl.chan_valid = (adccfg_ff[2] == 1'b0);
        mon_ctl.channel = adccfg_ff[2:0];
        mon_ctl.dig_bias_mon = bias_hi_ff[ldc_pkg::B_DMON_B];
        mon_ctl.dig_pd_mon = bias_hi_ff[ldc_pkg::B_DMON_P];
    end
endmodule

/* File: verilog/ldc_pkg.sv */
package ldc_pkg;
    // register indices; printed offsets are register numbers on the plain port
    localparam logic [7:0] REG_CORE0 = 8'h00;
    localparam logic [7:0] REG_CORE1 = 8'h01;
    localparam logic [7:0] REG_ADCCFG = 8'h03;
    localparam logic [7:0] REG_TXCTL = 8'h0A;
    localparam logic [7:0] REG_MODCODE = 8'h0C;
    localparam logic [7:0] REG_XPOINT = 8'h0E;
    localparam logic [7:0] REG_BIAS_LO = 8'h0F;
    localparam logic [7:0] REG_BIAS_HI = 8'h10;
    localparam logic [7:0] REG_BIAS_THR = 8'h11;
    localparam logic [7:0] REG_PD_THR = 8'h12;
    localparam logic [7:0] REG_ADC_MSB = 8'h28;
    localparam logic [7:0] REG_ADC_LSB = 8'h29;
    localparam logic [7:0] REG_STATUS = 8'h2B;
    localparam logic [7:0] REG_PD_SET = 8'h30;

    localparam logic [7:0] RST_CORE0 = 8'h41;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // field positions
    localparam int B_CHIP_EN = 0;
    localparam int B_PD_POL = 0;
    localparam int B_BIAS_POL = 1;
    localparam int B_BIAS_EN = 2;
    localparam int B_FLT_EN = 3;
    localparam int B_OPEN_LOOP = 4;
    localparam int B_PD_RNG_LO = 5;
    localparam int B_PD_FLT_TRIG = 7;
    localparam int B_ADC_OSC = 6;
    localparam int B_ADC_EN = 7;
    localparam int B_AMP_SRC = 0;
    localparam int B_OC_DIS = 2;
    localparam int B_TX_PD = 7;
    localparam int B_XP_DIR = 7;
    localparam int B_DMON_B = 5;
    localparam int B_DMON_P = 6;
    localparam int B_FLT_STAT = 5;

    // times in ns, board clock 40 ns
    localparam int CLK_NS = 40;
    localparam int T_INIT1_NS = 1000;
    localparam int T_INIT2_NS = 2000;
    localparam int T_FLTRST_NS = 200;
    localparam int T_NEGATE_NS = 400;
    localparam int INIT1_CYC = (T_INIT1_NS + CLK_NS - 1) / CLK_NS;
    localparam int INIT2_CYC = (T_INIT2_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLTRST_CYC = (T_FLTRST_NS + CLK_NS - 1) / CLK_NS;
    localparam int NEGATE_CYC = (T_NEGATE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } ldc_pwr_t;

    typedef enum logic [2:0] {
        MON_TEMP = 3'b000,
        MON_SUPPLY = 3'b001,
        MON_BIAS = 3'b010,
        MON_PD = 3'b011
    } ldc_mon_t;

    typedef struct packed {
        logic bias_on;
        logic bias_sink;
        logic open_loop;
        logic pd_sink;
        logic [1:0] pd_range;
        logic [9:0] bias_code;
    } ldc_bias_t;

    typedef struct packed {
        logic tx_powerdown;
        logic amp_from_pin;
        logic offset_cancel_on;
        logic [7:0] modulation_code;
        logic crosspoint_direction;
        logic [6:0] crosspoint_magnitude;
    } ldc_tx_t;

    typedef struct packed {
        logic adc_run;
        logic chan_valid;
        logic [2:0] channel;
        logic dig_bias_mon;
        logic dig_pd_mon;
    } ldc_mon_ctl_t;
endpackage

/* File: test/ldc_sva.sv */
`timescale 1ns/10ps
module ldc_sva (
    input wire logic mclk, // board clock
    input wire logic rst_n, // sync reset
    input wire logic [7:0] reg_addr, // register index
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic disable_pin, // disable input
    input wire logic fault_latch, // fault pin
    input wire logic tx_ready, // transmit allowed
    input wire logic regs_ready, // registers writable
    input wire ldc_pkg::ldc_bias_t bias_ctl, // bias control
    input wire ldc_pkg::ldc_tx_t tx_ctl, // transmit control
    input wire ldc_pkg::ldc_mon_ctl_t mon_ctl // monitor control
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [7:0] since_rst_ff;
    // saturates so the startup bounds never wrap in a long run
    always_ff @(posedge mclk) begin
        if (!rst_n) since_rst_ff <= 8'h00;
        else if (since_rst_ff != 8'hff) since_rst_ff <= since_rst_ff + 8'h01;
    end
    sequence s_dis_held;
        disable_pin [*8];
    endsequence
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_status_fault_bit: assert property (reg_rd && reg_addr == ldc_pkg::REG_STATUS
        && fault_latch |=> reg_rdata == 8'h20)
        else $error("status read does not show latched fault");
    a_fault_bias_off: assert property (fault_latch |-> !bias_ctl.bias_on)
        else $error("bias on while fault latched");
    a_disable_bias_off: assert property (disable_pin [*5] |-> !bias_ctl.bias_on)
        else $error("bias on while disabled");
    a_fault_clear_off: assert property (s_dis_held |-> !fault_latch)
        else $error("fault pin high while disabled");
    a_init_not_ready: assert property (since_rst_ff < 8'd24 |-> !regs_ready && !tx_ready)
        else $error("ready before init time");
    a_init_ready_late: assert property (since_rst_ff > 8'd26 |-> regs_ready)
        else $error("registers not ready after init time");
    a_early_write_drop: assert property (!regs_ready && reg_wr |=> $stable(tx_ctl)
        && $stable(bias_ctl))
        else $error("write taken before registers ready");
    a_chan_reserved: assert property (mon_ctl.chan_valid == !mon_ctl.channel[2])
        else $error("channel valid flag wrong");
endmodule
bind ldc_core ldc_sva u_sva (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
    .disable_pin, .fault_latch, .tx_ready, .regs_ready, .bias_ctl, .tx_ctl, .mon_ctl);

/* File: test/ldc_afe_model.sv */
`timescale 1ns/10ps
module ldc_afe_model #(
    parameter logic [9:0] ADC_VAL = 10'h2b6
) (
    input wire logic mclk, // board clock
    input wire logic rst_n, // sync reset
    input wire ldc_pkg::ldc_mon_ctl_t mon_ctl, // monitor control
    input wire ldc_pkg::ldc_bias_t bias_ctl, // bias control
    output logic [9:0] adc_result, // converter word
    output logic adc_done, // result strobe
    output logic [9:0] bias_meas // measured bias
);
    logic [2:0] tick_ff;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tick_ff <= 3'h0;
            adc_done <= 1'b0;
            adc_result <= ~ADC_VAL;
        end else begin
            tick_ff <= tick_ff + 3'h1;
            adc_done <= mon_ctl.adc_run && tick_ff == 3'h7;
            // word only valid with the strobe; otherwise it toggles
            adc_result <= (mon_ctl.adc_run && tick_ff == 3'h7) ? ADC_VAL : ~adc_result;
        end
    end
    assign bias_meas = bias_ctl.bias_on ? bias_ctl.bias_code : 10'h000;
endmodule

/* File: test/testbench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, disable_pin = 1'b0;
    logic bias_monitor_pin = 1'b0, pd_monitor_pin = 1'b0;
    logic [9:0] bias_meas, adc_result;
    logic [9:0] pd_meas = 10'h000;
    logic adc_done, fault_latch, tx_ready, regs_ready;
    ldc_pkg::ldc_bias_t bias_ctl;
    ldc_pkg::ldc_tx_t tx_ctl;
    ldc_pkg::ldc_mon_ctl_t mon_ctl;
    int fails = 0, check_count = 0;
    always #20 mclk = ~mclk;
    ldc_core dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disable_pin(disable_pin),
        .bias_monitor_pin(bias_monitor_pin), .pd_monitor_pin(pd_monitor_pin),
        .bias_meas(bias_meas), .pd_meas(pd_meas), .adc_result(adc_result), .adc_done(adc_done),
        .fault_latch(fault_latch), .tx_ready(tx_ready), .regs_ready(regs_ready),
        .bias_ctl(bias_ctl), .tx_ctl(tx_ctl), .mon_ctl(mon_ctl));
    ldc_afe_model afe (.mclk(mclk), .rst_n(rst_n), .mon_ctl(mon_ctl), .bias_ctl(bias_ctl),
        .adc_result(adc_result), .adc_done(adc_done), .bias_meas(bias_meas));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        `CHK(reg_rdata, e)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    // pulse the disable pin past the latch reset time with both monitor pins low and pd_meas zero
    task automatic recover;
        @(posedge mclk);
        disable_pin <= 1'b1;
        bias_monitor_pin <= 1'b0;
        pd_monitor_pin <= 1'b0;
        pd_meas <= 10'h000;
        cyc(10);
        @(posedge mclk);
        disable_pin <= 1'b0;
        cyc(16);
    endtask
    task automatic end_of_test;
        $display("fails=%0d check_count=%0d", fails, check_count);
        if (fails == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        wr(ldc_pkg::REG_CORE1, 8'h04);
        rd(ldc_pkg::REG_CORE0, 8'h41);
        `CHK(bias_ctl.bias_on, 1'b0)
        for (int i = 0; i < 200 && tx_ready !== 1'b1; i++) @(posedge mclk);
        cyc(0);
        `CHK(regs_ready, 1'b1)
        `CHK(tx_ready, 1'b1)
        rd(ldc_pkg::REG_CORE1, 8'h00);
        wr(ldc_pkg::REG_TXCTL, 8'h85);
        cyc(0);
        `CHK({tx_ctl.tx_powerdown, tx_ctl.amp_from_pin, tx_ctl.offset_cancel_on}, 3'b110)
        wr(ldc_pkg::REG_TXCTL, 8'h00);
        wr(ldc_pkg::REG_MODCODE, 8'ha5);
        wr(ldc_pkg::REG_XPOINT, 8'h93);
        cyc(0);
        `CHK({tx_ctl.tx_powerdown, tx_ctl.amp_from_pin, tx_ctl.offset_cancel_on}, 3'b001)
        `CHK(tx_ctl.modulation_code, 8'ha5)
        `CHK({tx_ctl.crosspoint_direction, tx_ctl.crosspoint_magnitude}, 8'h93)
        wr(ldc_pkg::REG_BIAS_LO, 8'h80);
        wr(ldc_pkg::REG_BIAS_HI, 8'h02);
        wr(ldc_pkg::REG_CORE1, 8'h73);
        cyc(14);
        `CHK(bias_ctl, {1'b0, 1'b1, 1'b1, 1'b1, 2'b11, 10'h000})
        wr(ldc_pkg::REG_CORE1, 8'h77);
        cyc(14);
        `CHK(bias_ctl.bias_on, 1'b1)
        `CHK(bias_ctl.bias_code, 10'h280)
        @(posedge mclk);
        disable_pin <= 1'b1;
        cyc(6);
        `CHK(bias_ctl.bias_on, 1'b0)
        rd(ldc_pkg::REG_CORE1, 8'h77);
        @(posedge mclk);
        disable_pin <= 1'b0;
        cyc(16);
        `CHK(bias_ctl.bias_on, 1'b1)
        wr(ldc_pkg::REG_BIAS_THR, 8'h10);
        wr(ldc_pkg::REG_BIAS_HI, 8'h22);
        wr(ldc_pkg::REG_CORE1, 8'h7f);
        cyc(6);
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b10)
        rd(ldc_pkg::REG_STATUS, 8'h20);
        @(posedge mclk);
        disable_pin <= 1'b1;
        cyc(10);
        `CHK(fault_latch, 1'b0)
        rd(ldc_pkg::REG_STATUS, 8'h00);
        @(posedge mclk);
        disable_pin <= 1'b0;
        cyc(20);
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b10)
        wr(ldc_pkg::REG_BIAS_THR, 8'hff);
        recover;
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b01)
        @(posedge mclk);
        bias_monitor_pin <= 1'b1;
        cyc(6);
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b10)
        recover;
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b01)
        @(posedge mclk);
        pd_monitor_pin <= 1'b1;
        cyc(6);
        `CHK(fault_latch, 1'b0)
        wr(ldc_pkg::REG_CORE1, 8'hff);
        cyc(4);
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b10)
        recover;
        wr(ldc_pkg::REG_PD_SET, 8'h40);
        @(posedge mclk);
        pd_meas <= 10'h060;
        cyc(4);
        `CHK(fault_latch, 1'b0)
        @(posedge mclk);
        pd_meas <= 10'h061;
        cyc(4);
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b10)
        @(posedge mclk);
        pd_meas <= 10'h000;
        wr(ldc_pkg::REG_CORE1, 8'hfb);
        cyc(10);
        `CHK(fault_latch, 1'b0)
        wr(ldc_pkg::REG_CORE1, 8'hff);
        cyc(16);
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b01)
        wr(ldc_pkg::REG_BIAS_HI, 8'h21);
        cyc(4);
        `CHK(fault_latch, 1'b0)
        wr(ldc_pkg::REG_BIAS_HI, 8'h20);
        cyc(4);
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b10)
        recover;
        wr(ldc_pkg::REG_PD_THR, 8'h10);
        @(posedge mclk);
        pd_meas <= 10'h041;
        cyc(4);
        `CHK(fault_latch, 1'b0)
        wr(ldc_pkg::REG_BIAS_HI, 8'h60);
        cyc(4);
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b10)
        recover;
        `CHK({fault_latch, bias_ctl.bias_on}, 2'b01)
        wr(ldc_pkg::REG_ADCCFG, 8'hc2);
        cyc(0);
        `CHK(mon_ctl, {1'b1, 1'b1, 3'b010, 1'b1, 1'b1})
        cyc(20);
        rd(ldc_pkg::REG_ADC_MSB, 8'had);
        rd(ldc_pkg::REG_ADC_LSB, 8'h02);
        for (int c = 0; c < 8; c++) begin
            wr(ldc_pkg::REG_ADCCFG, 8'hc0 | 8'(c));
            cyc(0);
            `CHK({mon_ctl.chan_valid, mon_ctl.channel}, {1'(c < 4), 3'(c)})
        end
        wr(ldc_pkg::REG_ADCCFG, 8'h43);
        cyc(0);
        `CHK(mon_ctl.adc_run, 1'b0)
        wr(ldc_pkg::REG_ADCCFG, 8'h83);
        cyc(0);
        `CHK(mon_ctl.adc_run, 1'b0)
        rd(8'h05, 8'h00);
        wr(ldc_pkg::REG_STATUS, 8'hff);
        rd(ldc_pkg::REG_STATUS, 8'h00);
        end_of_test;
    end
endmodule
